//--- rtl/ofd_alu.sv
// Purpose: ALU flags and multiply for the operand field decoder
// Assumes: 8-bit operands held stable while the outputs are sampled
// Notes: Pure combinational; the caller registers the outputs
`timescale 1ns/100ps
module ofd_alu (
   // Operands
   input wire logic [7:0] operand_a,
   input wire logic [7:0] operand_b,
   input wire logic carry_in,
   input wire logic [1:0] op_sel,
   // Results
   output logic [7:0] result,
   output logic [4:0] flags,
   output logic [15:0] product
);
   logic [8:0] sum;
   logic [4:0] low_sum;
   always_comb begin
      sum = 9'h000;
      low_sum = 5'h00;
      result = 8'h00;
      case (op_sel)
         2'h0: begin
            sum = {1'b0, operand_a} + {1'b0, operand_b};
            low_sum = {1'b0, operand_a[3:0]} + {1'b0, operand_b[3:0]};
         end
         2'h1: begin
            sum = {1'b0, operand_a} + {1'b0, operand_b} + {8'h00, carry_in};
            low_sum = {1'b0, operand_a[3:0]} + {1'b0, operand_b[3:0]} + {4'h0, carry_in};
         end
         2'h2: begin
            sum = {1'b0, operand_a} + {1'b0, ~operand_b} + 9'h001;
            low_sum = {1'b0, operand_a[3:0]} + {1'b0, ~operand_b[3:0]} + 5'h01;
         end
         default: begin
            sum = {1'b0, operand_a & operand_b};
         end
      endcase
      result = sum[7:0];
      // Order: negative, overflow, zero, digit carry, carry
      flags[4] = result[7];
      flags[3] = (op_sel == 2'h3) ? 1'b0 :
         ((operand_a[7] == (op_sel == 2'h2 ? ~operand_b[7] : operand_b[7])) && (result[7] != operand_a[7]));
      flags[2] = (result == 8'h00);
      flags[1] = low_sum[4];
      flags[0] = sum[8];
      product = {8'h00, operand_a} * {8'h00, operand_b};
   end
endmodule

//--- rtl/ofd_pkg.sv
// Purpose: Constants and types for the operand field decoder
// Assumes: 16-bit instruction words, 8-bit data path
// Notes: Register offsets are byte addresses on the AXI4-Lite slave
package ofd_pkg;
   // Register offsets
   localparam logic [7:0] OFD_INSTR_OFF = 8'h00;
   localparam logic [7:0] OFD_INSTR2_OFF = 8'h04;
   localparam logic [7:0] OFD_BANK_OFF = 8'h08;
   localparam logic [7:0] OFD_PTR_OFF = 8'h0C;
   localparam logic [7:0] OFD_FIELD0_OFF = 8'h10;
   localparam logic [7:0] OFD_FIELD1_OFF = 8'h14;
   localparam logic [7:0] OFD_TARGET_OFF = 8'h18;
   localparam logic [7:0] OFD_STATUS_OFF = 8'h1C;
   localparam logic [7:0] OFD_ALU_OFF = 8'h20;
   localparam logic [7:0] OFD_PROD_OFF = 8'h24;
   localparam logic [7:0] OFD_TABLE_OFF = 8'h28;
   // Reset values
   localparam logic [15:0] OFD_INSTR_RST = 16'h0000;
   localparam logic [3:0] OFD_BANK_RST = 4'h0;
   localparam logic [11:0] OFD_PTR_RST = 12'h000;
   localparam logic [20:0] OFD_TABLE_POINTER_RST = 21'h000000;
   // Field positions
   localparam int OFD_ACCESS_BIT = 8;
   localparam int OFD_DEST_BIT = 9;
   localparam int OFD_FAST_BIT = 0;
   localparam int OFD_CALL_FAST_BIT = 8;
   localparam int OFD_BIT_LSB = 9;
   localparam logic [3:0] OFD_SECOND_MARK = 4'hF;
   // Access RAM split point and last phase of the four-phase instruction cycle
   localparam logic [7:0] OFD_ACCESS_SPLIT = 8'h60;
   localparam logic [1:0] OFD_QPHASES = 2'h3;
   // Table pointer modes
   typedef enum logic [1:0] {
      OFD_TBL_KEEP = 2'h0,
      OFD_TBL_POSTINC = 2'h1,
      OFD_TBL_POSTDEC = 2'h2,
      OFD_TBL_PREINC = 2'h3
   } ofd_tbl_mode_t;
   // Decode sequencer states, Gray from IDLE through DECODE to FLUSH; FLUSH back to IDLE flips both bits
   typedef enum logic [1:0] {
      OFD_ST_IDLE = 2'h0,
      OFD_ST_DECODE = 2'h1,
      OFD_ST_FLUSH = 2'h3
   } ofd_state_t;
endpackage

//--- rtl/ofd_top.sv
// Purpose: Operand field decoder with AXI4-Lite register access
// Assumes: aclk 200 MHz, synchronous active-low reset
// Notes: Software writes instruction words; decoded fields read back
`timescale 1ns/100ps
module ofd_top (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // Register state
   logic [15:0] instr_reg, instr_next;
   logic [15:0] instr2_reg, instr2_next;
   logic [3:0] bank_select_register_reg, bank_select_register_next;
   logic [11:0] indirect_pointer_reg, indirect_pointer_next;
   logic [20:0] table_pointer_reg, table_pointer_next;
   logic [7:0] table_latch_reg, table_latch_next;
   logic [7:0] working_accumulator_reg, working_accumulator_next;
   logic [4:0] alu_flags_reg, alu_flags_next;
   logic [7:0] product_high_byte_reg, product_high_byte_next;
   logic [7:0] product_low_byte_reg, product_low_byte_next;
   logic [1:0] qphase_reg, qphase_next;
   logic flush_pending_reg, flush_pending_next;
   ofd_pkg::ofd_state_t state_reg, state_next;
   // Decoded fields, registered
   logic [31:0] field0_reg, field0_next;
   logic [31:0] field1_reg, field1_next;
   logic [31:0] target_reg, target_next;
   // AXI state
   logic awready_reg, awready_next, wready_reg, wready_next, bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic [7:0] awaddr_reg, awaddr_next;
   logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic arready_reg, arready_next, rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   // ALU wires
   logic [7:0] alu_result;
   logic [4:0] alu_flags;
   logic [15:0] alu_product;

   function automatic logic [31:0] merge_word(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [11:0] bank_address(input logic a, input logic [7:0] f, input logic [3:0] bank);
      if (!a) begin
         bank_address = (f < ofd_pkg::OFD_ACCESS_SPLIT) ? {4'h0, f} : {4'hF, f};
      end else begin
         bank_address = {bank, f};
      end
   endfunction

   ofd_alu u_alu (
      .operand_a(working_accumulator_reg),
      .operand_b(instr_reg[7:0]),
      .carry_in(alu_flags_reg[0]),
      .op_sel(instr_reg[11:10]),
      .result(alu_result),
      .flags(alu_flags),
      .product(alu_product)
   );

   // Decode combinational logic
   logic is_second, is_two_word, is_byte_op, is_bit_op, is_table, is_fast, is_rel_long, is_rel_short;
   logic is_ptr_load, is_indexed, is_mul, pc_change, commit;
   logic [7:0] bit_mask;
   always_comb begin
      is_second = (instr_reg[15:12] == ofd_pkg::OFD_SECOND_MARK);
      is_two_word = (instr_reg[15:12] == 4'hC) || (instr_reg[15:9] == 7'h76);
      is_bit_op = (instr_reg[15:14] == 2'h2) || (instr_reg[15:12] == 4'h7);
      is_byte_op = (instr_reg[15:14] == 2'h0) || (instr_reg[15:13] == 3'h2) || (instr_reg[15:12] == 4'h6);
      is_table = (instr_reg[15:3] == 13'h0001);
      is_fast = (instr_reg[15:1] == 15'h0009) || (instr_reg[15:9] == 7'h76);
      is_rel_long = (instr_reg[15:12] == 4'hD);
      is_rel_short = (instr_reg[15:11] == 5'h1C);
      is_ptr_load = (instr_reg[15:6] == 10'h3B8);
      is_indexed = (instr_reg[15:7] == 9'h1D6);
      is_mul = (instr_reg[15:9] == 7'h01);
      pc_change = is_rel_long || is_rel_short || is_fast;
      commit = (qphase_reg == ofd_pkg::OFD_QPHASES) && (state_reg == ofd_pkg::OFD_ST_DECODE);
      bit_mask = is_bit_op ? (8'h01 << instr_reg[11:ofd_pkg::OFD_BIT_LSB]) : 8'h00;
   end

   // Field assembly; field1 packs raw instruction bits, except the pointer-load and fast fields, which are gated
   always_comb begin
      field0_next = field0_reg;
      field1_next = field1_reg;
      target_next = target_reg;
      if (commit && !is_second) begin
         field0_next = {4'h0, bank_address(instr_reg[ofd_pkg::OFD_ACCESS_BIT], instr_reg[7:0],
            bank_select_register_reg),
            bit_mask, 3'h0, instr_reg[ofd_pkg::OFD_DEST_BIT], instr_reg[ofd_pkg::OFD_ACCESS_BIT],
            instr_reg[11:9]};
         field1_next = {(is_ptr_load ? instr_reg[5:4] : 2'h0),
            instr_reg[1:0],
            (instr_reg[15] ? instr_reg[ofd_pkg::OFD_CALL_FAST_BIT] :
               instr_reg[ofd_pkg::OFD_FAST_BIT]) & is_fast,
            instr_reg[11:0],
            instr_reg[7:0],
            instr_reg[6:0]};
         if (is_rel_long) begin
            target_next = {{21{instr_reg[10]}}, instr_reg[10:0]};
         end else if (is_rel_short) begin
            target_next = {{24{instr_reg[7]}}, instr_reg[7:0]};
         end else if (is_two_word) begin
            target_next = {instr2_reg[11:0], instr_reg[7:0], 12'h000} >> 12;
         end else if (is_indexed) begin
            target_next = {20'h00000, indirect_pointer_reg + {5'h00, instr_reg[6:0]}};
         end else begin
            target_next = {20'h00000, instr2_reg[11:0]};
         end
      end
   end

   // Execute state and sequencer
   always_comb begin
      state_next = state_reg;
      qphase_next = qphase_reg + 2'h1;
      flush_pending_next = flush_pending_reg;
      working_accumulator_next = working_accumulator_reg;
      alu_flags_next = alu_flags_reg;
      product_high_byte_next = product_high_byte_reg;
      product_low_byte_next = product_low_byte_reg;
      table_pointer_next = table_pointer_reg;
      table_latch_next = table_latch_reg;
      case (state_reg)
         ofd_pkg::OFD_ST_IDLE: begin
            qphase_next = 2'h0;
         end
         ofd_pkg::OFD_ST_DECODE: begin
            if (commit) begin
               state_next = ofd_pkg::OFD_ST_IDLE;
               if (is_second) begin
                  state_next = ofd_pkg::OFD_ST_IDLE;
               end else if (pc_change || is_two_word) begin
                  state_next = ofd_pkg::OFD_ST_FLUSH;
               end else if (is_mul) begin
                  {product_high_byte_next, product_low_byte_next} = alu_product;
               end else if (is_table) begin
                  table_latch_next = table_pointer_reg[7:0];
                  case (instr_reg[1:0])
                     ofd_pkg::OFD_TBL_POSTINC: table_pointer_next = table_pointer_reg + 21'h000001;
                     ofd_pkg::OFD_TBL_POSTDEC: table_pointer_next = table_pointer_reg - 21'h000001;
                     ofd_pkg::OFD_TBL_PREINC: begin
                        table_pointer_next = table_pointer_reg + 21'h000001;
                        table_latch_next = table_pointer_next[7:0];
                     end
                     default: table_pointer_next = table_pointer_reg;
                  endcase
               end else if (is_byte_op) begin
                  alu_flags_next = alu_flags;
                  if (!instr_reg[ofd_pkg::OFD_DEST_BIT]) begin
                     working_accumulator_next = alu_result;
                  end
               end
            end
         end
         ofd_pkg::OFD_ST_FLUSH: begin
            if (qphase_reg == ofd_pkg::OFD_QPHASES) begin
               state_next = ofd_pkg::OFD_ST_IDLE;
            end
         end
         default: state_next = ofd_pkg::OFD_ST_IDLE;
      endcase
      if (flush_pending_reg && state_reg == ofd_pkg::OFD_ST_IDLE) begin
         state_next = ofd_pkg::OFD_ST_DECODE;
         flush_pending_next = 1'b0;
      end
   end

   // AXI slave next state
   logic wr_fire;
   logic [31:0] wr_word;
   always_comb begin
      awready_next = awready_reg;
      wready_next = wready_reg;
      aw_held_next = aw_held_reg;
      w_held_next = w_held_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      arready_next = 1'b0;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      instr_next = instr_reg;
      instr2_next = instr2_reg;
      bank_select_register_next = bank_select_register_reg;
      indirect_pointer_next = indirect_pointer_reg;
      wr_fire = 1'b0;
      wr_word = 32'h00000000;
      awready_next = !aw_held_reg && !bvalid_reg && !(s_axi_awvalid && awready_reg);
      wready_next = !w_held_reg && !bvalid_reg && !(s_axi_wvalid && wready_reg);
      if (s_axi_awvalid && awready_reg) begin
         aw_held_next = 1'b1;
         awaddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
         w_held_next = 1'b1;
         wdata_next = s_axi_wdata;
         wstrb_next = s_axi_wstrb;
      end
      if (aw_held_reg && w_held_reg && !bvalid_reg) begin
         wr_fire = 1'b1;
         aw_held_next = 1'b0;
         w_held_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = 2'h0;
         case (awaddr_reg)
            ofd_pkg::OFD_INSTR_OFF: begin
               wr_word = merge_word({16'h0000, instr_reg}, wdata_reg, wstrb_reg);
               instr_next = wr_word[15:0];
            end
            ofd_pkg::OFD_INSTR2_OFF: begin
               wr_word = merge_word({16'h0000, instr2_reg}, wdata_reg, wstrb_reg);
               instr2_next = wr_word[15:0];
            end
            ofd_pkg::OFD_BANK_OFF: begin
               wr_word = merge_word({28'h0000000, bank_select_register_reg}, wdata_reg, wstrb_reg);
               bank_select_register_next = wr_word[3:0];
            end
            ofd_pkg::OFD_PTR_OFF: begin
               wr_word = merge_word({20'h00000, indirect_pointer_reg}, wdata_reg, wstrb_reg);
               indirect_pointer_next = wr_word[11:0];
            end
            default: bresp_next = 2'h2;
         endcase
      end
      if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end else if (!rvalid_reg && s_axi_arvalid && !arready_reg) begin
         arready_next = 1'b1;
      end
      if (s_axi_arvalid && arready_reg) begin
         rvalid_next = 1'b1;
         rresp_next = 2'h0;
         case (s_axi_araddr)
            ofd_pkg::OFD_INSTR_OFF: rdata_next = {16'h0000, instr_reg};
            ofd_pkg::OFD_INSTR2_OFF: rdata_next = {16'h0000, instr2_reg};
            ofd_pkg::OFD_BANK_OFF: rdata_next = {28'h0000000, bank_select_register_reg};
            ofd_pkg::OFD_PTR_OFF: rdata_next = {20'h00000, indirect_pointer_reg};
            ofd_pkg::OFD_FIELD0_OFF: rdata_next = field0_reg;
            ofd_pkg::OFD_FIELD1_OFF: rdata_next = field1_reg;
            ofd_pkg::OFD_TARGET_OFF: rdata_next = target_reg;
            ofd_pkg::OFD_STATUS_OFF: rdata_next = {28'h0000000, flush_pending_reg, 1'b0, state_reg};
            ofd_pkg::OFD_ALU_OFF: rdata_next = {19'h00000, alu_flags_reg, working_accumulator_reg};
            ofd_pkg::OFD_PROD_OFF: rdata_next = {16'h0000, product_high_byte_reg, product_low_byte_reg};
            ofd_pkg::OFD_TABLE_OFF: rdata_next = {3'h0, table_latch_reg, table_pointer_reg};
            default: begin
               rdata_next = 32'h00000000;
               rresp_next = 2'h2;
            end
         endcase
      end
   end

   // A write to the instruction word starts one decode
   logic start_decode;
   assign start_decode = wr_fire && (awaddr_reg == ofd_pkg::OFD_INSTR_OFF);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         instr_reg <= ofd_pkg::OFD_INSTR_RST;
         instr2_reg <= ofd_pkg::OFD_INSTR_RST;
         bank_select_register_reg <= ofd_pkg::OFD_BANK_RST;
         indirect_pointer_reg <= ofd_pkg::OFD_PTR_RST;
         table_pointer_reg <= ofd_pkg::OFD_TABLE_POINTER_RST;
         table_latch_reg <= 8'h00;
         working_accumulator_reg <= 8'h00;
         alu_flags_reg <= 5'h00;
         product_high_byte_reg <= 8'h00;
         product_low_byte_reg <= 8'h00;
         qphase_reg <= 2'h0;
         flush_pending_reg <= 1'b0;
         state_reg <= ofd_pkg::OFD_ST_IDLE;
         field0_reg <= 32'h00000000;
         field1_reg <= 32'h00000000;
         target_reg <= 32'h00000000;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
         awaddr_reg <= 8'h00;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= 2'h0;
      end else begin
         instr_reg <= instr_next;
         instr2_reg <= instr2_next;
         bank_select_register_reg <= bank_select_register_next;
         indirect_pointer_reg <= indirect_pointer_next;
         table_pointer_reg <= table_pointer_next;
         table_latch_reg <= table_latch_next;
         working_accumulator_reg <= working_accumulator_next;
         alu_flags_reg <= alu_flags_next;
         product_high_byte_reg <= product_high_byte_next;
         product_low_byte_reg <= product_low_byte_next;
         qphase_reg <= qphase_next;
         flush_pending_reg <= flush_pending_next | start_decode;
         state_reg <= state_next;
         field0_reg <= field0_next;
         field1_reg <= field1_next;
         target_reg <= target_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         awaddr_reg <= awaddr_next;
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
endmodule

//--- test/ofd_fetch_model.sv
// Purpose: Fetch path model handing instruction words to the bench
// Assumes: Two formats, byte-oriented add and bit set
// Notes: Don't-care bits are emitted as zero
`timescale 1ns/100ps
module ofd_fetch_model (
   // Field selects
   input wire logic fmt,
   input wire logic [2:0] bitn,
   input wire logic dsel,
   input wire logic asel,
   input wire logic [7:0] fadr,
   // Fetched word
   output logic [15:0] word
);
   assign word = fmt ? {4'h8, bitn, asel, fadr} : {6'h09, dsel, asel, fadr};
endmodule

//--- test/ofd_top_sva.sv
// Purpose: Bus timing checks for the operand field decoder
// Assumes: One clock, synchronous active-low reset
// Notes: Sees only the top-level ports
`timescale 1ns/100ps
module ofd_top_sva (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write channels
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read channels
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
   property p_ar_pulse; s_axi_arready |=> !s_axi_arready; endproperty
   a_ar_pulse: assert property (p_ar_pulse) else $error("arready longer than one cycle");
   property p_r_after_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_after_ar: assert property (p_r_after_ar) else $error("read answer late");
   property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken while answer pending");
   property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_aw_block: assert property (p_aw_block) else $error("write taken while response pending");
   property p_b_after_w;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_b_after_w: assert property (p_b_after_w) else $error("write response late");
   property p_rresp; s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0; endproperty
   a_rresp: assert property (p_rresp) else $error("bad read error answer");
   property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_b_drop: assert property (p_b_drop) else $error("write response repeated");
endmodule
bind ofd_top ofd_top_sva ofd_top_sva_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

//--- test/operand_field_decoder_tb.sv
// Purpose: Self-checking bench for the operand field decoder
// Assumes: AXI4-Lite master tasks, 200 MHz clock
// Notes: Field layout of the decoded register follows the hand-over
`timescale 1ns/100ps
module operand_field_decoder_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, fadr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic fmt = 1'b0, dsel = 1'b0, asel = 1'b0;
   logic [2:0] bitn = 3'h0;
   logic [15:0] word;
   logic [11:0] ea;
   int n_fail = 0, tests_run = 0, cycles = 0;
   ofd_top ofd_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   ofd_fetch_model ofd_fetch_model_inst (.fmt(fmt), .bitn(bitn), .dsel(dsel), .asel(asel), .fadr(fadr), .word(word));
   initial forever #2.5 aclk = ~aclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         report_and_stop;
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      v = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Issue one word and let its instruction cycles finish
   task automatic run(input logic [15:0] w);
      wr(ofd_pkg::OFD_INSTR_OFF, {16'h0000, w});
      repeat (4) rd(ofd_pkg::OFD_STATUS_OFF);
      chk({30'h0, v[1:0]}, 32'h0);
   endtask
   // Issue the model's word once settled, fetch field0
   task automatic decode;
      #1;
      run(word);
      rd(ofd_pkg::OFD_FIELD0_OFF);
   endtask
   task automatic t_control;
      run(16'hD7FF);
      rd(ofd_pkg::OFD_TARGET_OFF);
      chk(v, 32'hFFFF_FFFF);
      run(16'hF123);
      rd(ofd_pkg::OFD_TARGET_OFF);
      chk(v, 32'hFFFF_FFFF);
      run(16'h0009);
      rd(ofd_pkg::OFD_TABLE_OFF);
      chk(v, 32'h0000_0001);
   endtask
   task automatic t_reset;
      rd(ofd_pkg::OFD_INSTR_OFF);
      chk(v, 32'h0);
      rd(ofd_pkg::OFD_BANK_OFF);
      chk(v, 32'h0);
      rd(ofd_pkg::OFD_TABLE_OFF);
      chk(v, 32'h0);
   endtask
   task automatic t_bank_and_holes;
      wr(ofd_pkg::OFD_BANK_OFF, 32'hFFFF_FFF5);
      chk({30'h0, r}, 32'h0);
      rd(ofd_pkg::OFD_BANK_OFF);
      chk(v, 32'h5);
      s_axi_wstrb <= 4'h2;
      wr(ofd_pkg::OFD_PTR_OFF, 32'h0000_AB00);
      s_axi_wstrb <= 4'hF;
      rd(ofd_pkg::OFD_PTR_OFF);
      chk(v, 32'h0000_0B00);
      wr(8'h3C, 32'h1234_5678);
      chk({30'h0, r}, 32'h2);
      rd(8'h3C);
      chk({r, v[29:0]}, 32'h8000_0000);
   endtask
   task automatic t_access_dest;
      fmt = 1'b0;
      for (int i = 0; i < 8; i++) begin
         asel = i[0];
         dsel = i[1];
         fadr = i[2] ? 8'h60 : 8'h5F;
         ea = asel ? {4'h5, fadr} : (fadr < 8'h60 ? {4'h0, fadr} : {4'hF, fadr});
         decode;
         chk({18'h0, v[27:16], v[4], v[3]}, {18'h0, ea, dsel, asel});
      end
   endtask
   task automatic t_bits;
      fmt = 1'b1;
      asel = 1'b1;
      fadr = 8'hFF;
      for (int b = 0; b < 8; b++) begin
         bitn = b[2:0];
         decode;
         chk({8'h0, v[27:16], v[15:8], v[3:0]}, {8'h0, 12'h5FF, 8'h01 << b, 1'b1, b[2:0]});
      end
   endtask
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_bank_and_holes;
      t_access_dest;
      t_bits;
      t_control;
      report_and_stop;
   end
endmodule
